// *** hw/spi_pkg.sv ***
// constants shared by the serial peripheral port and its rate generator
// Behaviour
// - control bit 6 off deactivates the serial port, on activates it
// - select disable ignores slave select, except slave role with phase zero
// - when slave select is unused, the select pin is released for general use
// - control bit 4 zero gives slave role, one gives master role
// - control bit 3 sets the idle level of the serial clock
// - bits 7, 1 and 0 together select the master clock rate
package spi_pkg;
	// ****************************************
	// register bus
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_DATA = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h03;
	localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

	// ****************************************
	// control fields
	// ****************************************
	localparam int RATE_SELECT_HIGH = 7;
	localparam int PORT_ENABLE_BIT = 6;
	localparam int SELECT_DISABLE_BIT = 5;
	localparam int ROLE_SELECT_BIT = 4;
	localparam int CLOCK_IDLE_LEVEL_BIT = 3;
	localparam int CLOCK_SAMPLING_EDGE_BIT = 2;
	localparam int RATE_SELECT_MID = 1;
	localparam int RATE_SELECT_LOW = 0;

	// ****************************************
	// status fields
	// ****************************************
	localparam int ST_W = 3;
	localparam int ST_DONE = 0;
	localparam int ST_MODE_FAULT = 1;
	localparam int ST_WRITE_COLLISION = 2;
	localparam int ST_BUSY = 7;
	localparam logic [ST_W-1:0] STATUS_RESET = 3'h0;

	// ****************************************
	// timing
	// ****************************************
	localparam int SYNC_LAT = 2;
	localparam int EDGES_PER_BYTE = 2 * DATA_W;
	// wide enough for the slowest half period of 256 cycles
	localparam int RATE_CNT_W = 9;

	// half period of the master serial clock in peripheral clocks
	function automatic logic [RATE_CNT_W-1:0] rate_half_cycles(input logic [2:0] rate);
		rate_half_cycles = RATE_CNT_W'(2) << rate;
	endfunction
endpackage

// *** hw/spi_rate_tick.sv ***
// half-period tick generator for the master serial clock
`timescale 1ns/100ps
module spi_rate_tick (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [2:0] rate,
	output logic tick
);
	import spi_pkg::*;

	logic [RATE_CNT_W-1:0] cnt_ff;
	logic tick_ff;

	// ****************************************
	// divider
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (reset || !run) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (cnt_ff == rate_half_cycles(rate) - RATE_CNT_W'(1)) begin
			cnt_ff <= '0;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + RATE_CNT_W'(1);
			tick_ff <= 1'b0;
		end
	end

	assign tick = tick_ff;
endmodule

// *** hw/spi_master_slave_port.sv ***
// serial peripheral port, master or slave, with its register file
`timescale 1ns/100ps
module spi_master_slave_port (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [spi_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [spi_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [spi_pkg::DATA_W-1:0] reg_rdata,
	output logic irq,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe,
	input wire logic ss_n_i,
	output logic ss_pin_claimed
);
	import spi_pkg::*;

	typedef enum logic [0:0] {
		M_IDLE = 1'b0,
		M_RUN = 1'b1
	} mstate_t;

	logic [DATA_W-1:0] control_ff, mask_ff, tx_hold_ff, tx_sh_ff, rx_sh_ff, rx_data_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [ST_W-1:0] status_ff;
	logic irq_ff;
	mstate_t mstate_ff;
	logic [3:0] edge_cnt_ff, rx_cnt_ff;
	logic sck_lvl_ff, out_bit_ff;
	logic sck_m_ff, sck_s_ff, sck_d_ff;
	logic ss_m_ff, ss_s_ff, sel_d_ff;
	logic mosi_m_ff, mosi_s_ff, miso_m_ff, miso_s_ff;
	logic [SYNC_LAT-1:0] smp_pipe_ff;
	logic sck_oe_ff, mosi_oe_ff, miso_oe_ff, claimed_ff;
	logic tick;

	// ****************************************
	// control decode
	// ****************************************
	logic en, master, clock_idle_level_bit, clock_sampling_edge_bit, ss_use, sel, busy;
	logic [2:0] rate;
	assign en = control_ff[PORT_ENABLE_BIT];
	assign master = control_ff[ROLE_SELECT_BIT];
	assign clock_idle_level_bit = control_ff[CLOCK_IDLE_LEVEL_BIT];
	assign clock_sampling_edge_bit = control_ff[CLOCK_SAMPLING_EDGE_BIT];
	assign rate = {control_ff[RATE_SELECT_HIGH], control_ff[RATE_SELECT_MID],
		control_ff[RATE_SELECT_LOW]};
	// phase zero in slave role needs select to frame the first bit
	assign ss_use = !control_ff[SELECT_DISABLE_BIT] || (!master && !clock_sampling_edge_bit);
	assign sel = en && !master && (!ss_use || !ss_s_ff);
	assign busy = (mstate_ff == M_RUN) || (rx_cnt_ff != 4'h0);

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sck_m_ff <= 1'b0;
			sck_s_ff <= 1'b0;
			sck_d_ff <= 1'b0;
			ss_m_ff <= 1'b1;
			ss_s_ff <= 1'b1;
			mosi_m_ff <= 1'b0;
			mosi_s_ff <= 1'b0;
			miso_m_ff <= 1'b0;
			miso_s_ff <= 1'b0;
		end else begin
			sck_m_ff <= sck_i;
			sck_s_ff <= sck_m_ff;
			sck_d_ff <= sck_s_ff;
			ss_m_ff <= ss_n_i;
			ss_s_ff <= ss_m_ff;
			mosi_m_ff <= mosi_i;
			mosi_s_ff <= mosi_m_ff;
			miso_m_ff <= miso_i;
			miso_s_ff <= miso_m_ff;
		end
	end

	// ****************************************
	// event decode
	// ****************************************
	logic wr_ctl, wr_st, wr_data, wr_mask, m_lead, m_edge, s_edge, s_lead;
	logic mode_fault, start_m, sel_rise, load, shift_ev, sample_ev, sample_bit, byte_done;
	assign wr_ctl = reg_wr && reg_addr == OFS_CONTROL;
	assign wr_st = reg_wr && reg_addr == OFS_STATUS;
	assign wr_data = reg_wr && reg_addr == OFS_DATA;
	assign wr_mask = reg_wr && reg_addr == OFS_MASK;
	// master: an external low on select while in use aborts the frame
	assign mode_fault = en && master && ss_use && !ss_s_ff && mstate_ff == M_RUN;
	assign start_m = wr_data && !busy && en && master;
	assign m_edge = tick && mstate_ff == M_RUN;
	assign m_lead = !edge_cnt_ff[0];
	assign s_edge = sel && sel_d_ff && (sck_s_ff != sck_d_ff);
	assign s_lead = sck_d_ff == clock_idle_level_bit;
	assign sel_rise = sel && !sel_d_ff;
	// in slave role with select unused the next byte is armed as soon as one completes
	assign load = start_m || (wr_data && !busy && sel) || sel_rise
		|| (byte_done && sel && !ss_use);
	assign shift_ev = (m_edge && m_lead == clock_sampling_edge_bit) || (s_edge && s_lead == clock_sampling_edge_bit);
	// master samples two cycles late to match the delay of the miso synchroniser
	assign sample_ev = smp_pipe_ff[SYNC_LAT-1] || (s_edge && s_lead != clock_sampling_edge_bit);
	assign sample_bit = master ? miso_s_ff : mosi_s_ff;
	assign byte_done = sample_ev && rx_cnt_ff == 4'(DATA_W - 1);

	// ****************************************
	// master sequencer
	// ****************************************
	spi_rate_tick u_rate (
		.ref_clk(ref_clk),
		.reset(reset),
		.run(mstate_ff == M_RUN),
		.rate(rate),
		.tick(tick)
	);

	always_ff @(posedge ref_clk) begin
		if (reset || !en || mode_fault) begin
			mstate_ff <= M_IDLE;
			edge_cnt_ff <= 4'h0;
			sck_lvl_ff <= 1'b0;
		end else begin
			unique case (mstate_ff)
				M_IDLE: begin
					edge_cnt_ff <= 4'h0;
					if (start_m) begin
						mstate_ff <= M_RUN;
					end
				end
				M_RUN: begin
					if (m_edge) begin
						sck_lvl_ff <= !sck_lvl_ff;
						edge_cnt_ff <= edge_cnt_ff + 4'h1;
						if (edge_cnt_ff == 4'(EDGES_PER_BYTE - 1)) begin
							mstate_ff <= M_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !en) begin
			smp_pipe_ff <= '0;
			sel_d_ff <= 1'b0;
		end else begin
			smp_pipe_ff <= {smp_pipe_ff[SYNC_LAT-2:0], m_edge && m_lead != clock_sampling_edge_bit};
			sel_d_ff <= sel;
		end
	end

	// ****************************************
	// shift registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_hold_ff <= DATA_RESET;
			tx_sh_ff <= DATA_RESET;
			out_bit_ff <= 1'b0;
		end else begin
			if (wr_data && !busy) begin
				tx_hold_ff <= reg_wdata;
			end
			if (load) begin
				// phase zero must present the first bit before the first edge
				tx_sh_ff <= clock_sampling_edge_bit ? (wr_data ? reg_wdata : tx_hold_ff)
					: {(wr_data ? reg_wdata[DATA_W-2:0] : tx_hold_ff[DATA_W-2:0]), 1'b0};
				if (!clock_sampling_edge_bit) begin
					out_bit_ff <= wr_data ? reg_wdata[DATA_W-1] : tx_hold_ff[DATA_W-1];
				end
			end else if (shift_ev) begin
				out_bit_ff <= tx_sh_ff[DATA_W-1];
				tx_sh_ff <= {tx_sh_ff[DATA_W-2:0], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !en || mode_fault || (!master && !sel)) begin
			rx_cnt_ff <= 4'h0;
			rx_sh_ff <= DATA_RESET;
		end else if (sample_ev) begin
			rx_sh_ff <= {rx_sh_ff[DATA_W-2:0], sample_bit};
			rx_cnt_ff <= byte_done ? 4'h0 : rx_cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_data_ff <= DATA_RESET;
		end else if (byte_done) begin
			rx_data_ff <= {rx_sh_ff[DATA_W-2:0], sample_bit};
		end
	end

	// ****************************************
	// pins
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sck_oe_ff <= 1'b0;
			mosi_oe_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
			claimed_ff <= 1'b0;
		end else begin
			sck_oe_ff <= en && master;
			mosi_oe_ff <= en && master;
			miso_oe_ff <= sel;
			claimed_ff <= en && ss_use;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sck_o <= 1'b0;
			mosi_o <= 1'b0;
			miso_o <= 1'b0;
		end else begin
			sck_o <= clock_idle_level_bit ^ sck_lvl_ff;
			mosi_o <= out_bit_ff;
			miso_o <= out_bit_ff;
		end
	end

	assign sck_oe = sck_oe_ff;
	assign mosi_oe = mosi_oe_ff;
	assign miso_oe = miso_oe_ff;
	assign ss_pin_claimed = claimed_ff;

	// ****************************************
	// registers and interrupt
	// ****************************************
	logic [ST_W-1:0] st_set;
	assign st_set = {wr_data && busy, mode_fault, byte_done};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			control_ff <= CONTROL_RESET;
			mask_ff <= MASK_RESET;
		end else begin
			if (wr_ctl) begin
				control_ff <= reg_wdata;
			end
			if (wr_mask) begin
				mask_ff <= reg_wdata;
			end
		end
	end

	// a set in the same cycle as a write-one clear wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			status_ff <= STATUS_RESET;
		end else begin
			status_ff <= (status_ff & ~(wr_st ? reg_wdata[ST_W-1:0] : '0)) | st_set;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & mask_ff[ST_W-1:0]);
			if (reg_rd) begin
				unique case (reg_addr)
					OFS_CONTROL: rdata_ff <= control_ff;
					OFS_STATUS: rdata_ff <= {busy, 4'h0, status_ff};
					OFS_DATA: rdata_ff <= rx_data_ff;
					OFS_MASK: rdata_ff <= {5'h0, mask_ff[ST_W-1:0]};
					default: rdata_ff <= '0;
				endcase
			end else begin
				rdata_ff <= '0;
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign irq = irq_ff;
endmodule

// *** tb/spi_port_asserts.sv ***
// concurrent checks on the serial port pins and register bus
`timescale 1ns/100ps
module spi_port_asserts (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [spi_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [spi_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [spi_pkg::DATA_W-1:0] reg_rdata,
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic mosi_oe,
	input wire logic miso_oe,
	input wire logic ss_pin_claimed
);
	import spi_pkg::*;
	logic [7:0] ctl_ff;
	logic [8:0] gap_ff;
	logic [3:0] tog_ff;
	logic sck_ff;
	wire logic on = ctl_ff[6];
	wire logic use_ss = on && !(ctl_ff[5] && (ctl_ff[4] || ctl_ff[2]));
	wire logic [8:0] half = 9'h2 << {ctl_ff[7], ctl_ff[1:0]};
	wire logic tog = sck_o != sck_ff;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge ref_clk) begin
		if (reset)
			ctl_ff <= CONTROL_RESET;
		else if (reg_wr && reg_addr == OFS_CONTROL)
			ctl_ff <= reg_wdata;
	end
	// toggles counted per byte; an abort leaves this out of step until sck_oe drops
	always_ff @(posedge ref_clk) begin
		sck_ff <= sck_o;
		gap_ff <= tog ? 9'h0 : gap_ff + 9'h1;
		tog_ff <= !sck_oe ? 4'h0 : tog_ff + 4'(tog);
	end
	a_reset_quiet: assert property (
		$fell(reset) |-> !sck_oe && !mosi_oe && !miso_oe && !ss_pin_claimed)
		else $error("pins driven after reset");
	a_off_quiet: assert property (
		!on && !$past(on) |-> !sck_oe && !mosi_oe && !miso_oe && !ss_pin_claimed)
		else $error("disabled port drives pins");
	a_master_drive: assert property (
		on && ctl_ff[4] && $past(on && ctl_ff[4]) |-> sck_oe && mosi_oe && !miso_oe)
		else $error("master not driving");
	a_slave_listen: assert property (
		on && !ctl_ff[4] && $past(on && !ctl_ff[4]) |-> !sck_oe && !mosi_oe)
		else $error("slave drives clock");
	a_miso_gate: assert property (
		miso_oe |-> $past(on && !ctl_ff[4]))
		else $error("miso driven outside slave role");
	a_select_claim: assert property (
		ss_pin_claimed == $past(use_ss))
		else $error("select pin claim wrong");
	a_idle_level: assert property (
		$rose(sck_oe) |-> sck_o == ctl_ff[3])
		else $error("clock idle level wrong");
	a_half_period: assert property (
		sck_oe && tog && tog_ff != 4'h0 |-> gap_ff == half - 9'h1)
		else $error("clock half period wrong");
	a_read_control: assert property (
		$past(reg_rd) && $past(reg_addr) == OFS_CONTROL |-> reg_rdata == $past(ctl_ff))
		else $error("control read back wrong");
endmodule

// *** tb/spi_far_device.sv ***
// far side of the link: slave for master runs, master with its own clock for slave runs
`timescale 1ns/100ps
module spi_far_device (
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic sel_n,
	input wire logic clock_idle_level_bit,
	input wire logic clock_sampling_edge_bit,
	output logic sck_drv,
	output logic mosi_drv,
	output logic miso_drv
);
	logic [7:0] s_tx, s_rx, m_rx;
	logic mst = 1'b0;
	logic m_sck = 1'b0;
	initial mosi_drv = 1'b0;
	initial miso_drv = 1'b0;
	// clock stands at its idle level outside frames
	assign sck_drv = mst ? m_sck : clock_idle_level_bit;
	always @(negedge sel_n) if (!clock_sampling_edge_bit) begin
		miso_drv = s_tx[7];
		s_tx = {s_tx[6:0], 1'b0};
	end
	// released line shows no stale bit
	always @(posedge sel_n) miso_drv = ~miso_drv;
	always @(sck) if (!sel_n && !mst) begin
		if ((sck != clock_idle_level_bit) ^ clock_sampling_edge_bit)
			s_rx = {s_rx[6:0], mosi};
		else begin
			miso_drv = s_tx[7];
			s_tx = {s_tx[6:0], 1'b0};
		end
	end
	task automatic xfer(input logic [7:0] t);
		// start from the idle level so that taking over the clock makes no edge
		m_sck = clock_idle_level_bit;
		mst = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			if (!clock_sampling_edge_bit)
				mosi_drv = t[i];
			#24 m_sck = !clock_idle_level_bit;
			if (clock_sampling_edge_bit)
				mosi_drv = t[i];
			else
				m_rx = {m_rx[6:0], miso};
			#24 m_sck = clock_idle_level_bit;
			if (clock_sampling_edge_bit)
				m_rx = {m_rx[6:0], miso};
		end
		#24 mosi_drv = !mosi_drv;
		mst = 1'b0;
	endtask
endmodule

// *** tb/spi_master_slave_port_test.sv ***
// self-checking bench: register bus, master and slave transfers, interrupt
`timescale 1ns/100ps
module spi_master_slave_port_test;
	import spi_pkg::*;
	logic ref_clk, reset, reg_wr, reg_rd, ss_n_i, clock_idle_level_bit, clock_sampling_edge_bit;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v, t, r;
	logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_pin_claimed;
	logic sck_d, mosi_d, miso_d;
	int num_errors = 0;
	int n_checks = 0;
	wire logic sck_i = sck_oe ? sck_o : sck_d;
	wire logic mosi_i = mosi_oe ? mosi_o : mosi_d;
	wire logic miso_i = miso_oe ? miso_o : miso_d;
	spi_master_slave_port dut_u (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .sck_i, .sck_o, .sck_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i,
		.miso_o, .miso_oe, .ss_n_i, .ss_pin_claimed);
	spi_far_device far_u (.sck(sck_i), .mosi(mosi_i), .miso(miso_i), .sel_n(ss_n_i), .clock_idle_level_bit,
		.clock_sampling_edge_bit, .sck_drv(sck_d), .mosi_drv(mosi_d), .miso_drv(miso_d));
	function automatic logic [7:0] cfg(input logic en, sd, ms, po, ph, logic [2:0] rt);
		cfg = {rt[2], en, sd, ms, po, ph, rt[1:0]};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, s);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic wait_st(input logic [7:0] m, e);
		r = ~e;
		for (int k = 0; k < 3000 && (r & m) !== e; k++)
			rd(OFS_STATUS, r);
	endtask
	// clears only the enable bit, so polarity and phase never change while enabled
	task automatic port_off;
		rd(OFS_CONTROL, r);
		wr(OFS_CONTROL, r & 8'hbf);
	endtask
	task automatic end_sim;
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// slowest byte is 4096 cycles; the whole run needs well under this
	initial begin
		#400000 num_errors++;
		end_sim;
	end
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, clock_idle_level_bit, clock_sampling_edge_bit} = '0;
		reset = 1'b1;
		ss_n_i = 1'b1;
		v = $urandom(42);
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		rd(OFS_CONTROL, r);
		chk("control reset", CONTROL_RESET, r);
		rd(8'h10, r);
		chk("unmapped", 8'h00, r);
		repeat (4) begin
			v = 8'($urandom) & 8'hbf;
			wr(OFS_CONTROL, v);
			rd(OFS_CONTROL, r);
			chk("control", v, r);
		end
		for (int i = 0; i < 8; i++) begin
			port_off;
			clock_idle_level_bit = i[0];
			clock_sampling_edge_bit = i[1];
			wr(OFS_CONTROL, cfg(1'b0, 1'b1, 1'b1, i[0], i[1], i[2:0]));
			wr(OFS_CONTROL, cfg(1'b1, 1'b1, 1'b1, i[0], i[1], i[2:0]));
			wr(OFS_MASK, {7'h0, i[0]});
			t = 8'($urandom);
			v = 8'($urandom);
			far_u.s_tx = t;
			ss_n_i <= 1'b0;
			wr(OFS_DATA, v);
			if (i == 7) wr(OFS_DATA, ~v);
			wait_st(8'h01, 8'h01);
			chk("far got", v, far_u.s_rx);
			// phase zero still owes its last trailing edge after the done flag
			wait_st(8'h80, 8'h00);
			chk("busy", 8'h00, r & 8'h80);
			chk("collision", {5'h0, i == 7, 2'h0}, r & 8'h04);
			chk("idle", {7'h0, i[0]}, {7'h0, sck_o});
			rd(OFS_DATA, r);
			chk("master got", t, r);
			chk("irq", {7'h0, i[0]}, {7'h0, irq});
			wr(OFS_STATUS, 8'h01);
			repeat (2) @(posedge ref_clk);
			chk("irq clear", 8'h00, {7'h0, irq});
			ss_n_i <= 1'b1;
		end
		port_off;
		wr(OFS_CONTROL, cfg(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0));
		clock_idle_level_bit = 1'b0;
		clock_sampling_edge_bit = 1'b0;
		wr(OFS_CONTROL, cfg(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0));
		ss_n_i <= 1'b0;
		wr(OFS_DATA, 8'h5a);
		wait_st(8'h02, 8'h02);
		chk("fault", 8'h02, r & 8'h02);
		chk("claim", 8'h01, {7'h0, ss_pin_claimed});
		ss_n_i <= 1'b1;
		for (int j = 0; j < 8; j++) begin
			port_off;
			wr(OFS_CONTROL, cfg(1'b0, j[2], 1'b0, j[0], j[1], 3'h0));
			clock_idle_level_bit = j[0];
			clock_sampling_edge_bit = j[1];
			wr(OFS_STATUS, 8'h07);
			wr(OFS_CONTROL, cfg(1'b1, j[2], 1'b0, j[0], j[1], 3'h0));
			t = 8'($urandom);
			v = 8'($urandom);
			wr(OFS_DATA, t);
			ss_n_i <= j[2] & j[1];
			repeat (6) @(posedge ref_clk);
			far_u.xfer(v);
			wait_st(8'h01, 8'h01);
			chk("slave sent", t, far_u.m_rx);
			rd(OFS_DATA, r);
			chk("slave got", v, r);
			chk("claim", {7'h0, !(j[2] & j[1])}, {7'h0, ss_pin_claimed});
			ss_n_i <= 1'b1;
		end
		end_sim;
	end
endmodule
bind spi_master_slave_port spi_port_asserts chk_u (.ref_clk, .reset, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .sck_o, .sck_oe, .mosi_oe, .miso_oe, .ss_pin_claimed);
